// ---- logic/bec_pkg.sv ----
package bec_pkg;

  // register bus geometry
  localparam int unsigned BUS_ADDR_W = 8;
  localparam int unsigned BUS_DATA_W = 32;
  localparam int unsigned CSR_W = 8;

  // register byte addresses
  localparam logic [BUS_ADDR_W-1:0] IN_CSR_OFS = 8'h00;
  localparam logic [BUS_ADDR_W-1:0] OUT_CSR_OFS = 8'h04;

  // bulk in control/status field positions
  localparam int unsigned IN_TX_SHORT_PACKET = 7;
  localparam int unsigned IN_RSVD = 6;
  localparam int unsigned IN_FORCE_STALL = 5;
  localparam int unsigned IN_SENT_STALL = 4;
  localparam int unsigned IN_TX_UNDERRUN = 3;
  localparam int unsigned IN_TX_FIFO_FLUSH = 2;
  localparam int unsigned IN_TX_PACKET_COMPLETE = 1;
  localparam int unsigned IN_TX_FIFO_SERVICE = 0;

  // bulk out control/status field positions
  localparam int unsigned OUT_FORCE_STALL = 5;
  localparam int unsigned OUT_SENT_STALL = 4;
  localparam int unsigned OUT_RSVD_HI = 3;
  localparam int unsigned OUT_RSVD_LO = 2;
  localparam int unsigned OUT_RX_PACKET_COMPLETE = 1;
  localparam int unsigned OUT_RX_FIFO_SERVICE = 0;

  // reset values
  localparam logic [CSR_W-1:0] IN_CSR_RESET = 8'h01;
  localparam logic [CSR_W-1:0] OUT_CSR_RESET = 8'h00;

  // packet buffering
  localparam int unsigned MAX_PKT_BYTES = 64;
  localparam logic [1:0] BUF_COUNT = 2'h2;

  typedef enum logic [1:0] {
    HS_DATA,
    HS_ACK,
    HS_NAK,
    HS_STALL
  } bec_hs_code_t;

  typedef struct packed {
    logic valid;
    bec_hs_code_t code;
  } bec_hs_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [BUS_ADDR_W-1:0] addr;
    logic [BUS_DATA_W-1:0] wdata;
  } bec_bus_req_t;

  // one-cycle events from the serial engine, same clock
  typedef struct packed {
    logic in_token;
    logic out_token;
    logic tx_sent;
    logic tx_underrun;
    logic rx_pkt_done;
    logic in_proto_err;
    logic out_proto_err;
    logic in_clear_feature;
    logic out_clear_feature;
  } bec_sie_ev_t;

  typedef struct packed {
    logic flag;
  } bec_flag_state_t;

endpackage : bec_pkg

// ---- logic/bec_sticky_flag.sv ----
`timescale 1ns/1ps
module bec_sticky_flag (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic set_i,
  input wire logic clr_i,
  output logic flag_o
);
  import bec_pkg::*;

  bec_flag_state_t s_q;
  bec_flag_state_t s_d;

  // set beats a same-cycle clear so no event is lost
  always_comb begin
    s_d = s_q;
    if (clr_i) begin
      s_d.flag = 1'b0;
    end
    if (set_i) begin
      s_d.flag = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign flag_o = s_q.flag;

endmodule : bec_sticky_flag

// ---- logic/bec_bulk_ep_ctrl.sv ----
// Notes on behaviour
// - writing one to in bit 7 commits the partial transmit buffer as short packet
// - in bit 6 is reserved and reads zero
// - while in force-stall is one, every in token gets stall
// - sent-stall sets after a forced stall goes out; cleared by writing one
// - transmit underrun sets in bit 3; cleared by writing one
// - writing one to in bit 2 flushes transmit fifo; reads zero
// - in bit 1 sets when a packet was sent; write one clears
// - in bit 0 is one while transmit fifo has room for a packet
// - out service flag sets once a complete checked packet is held
// - out service flag stays until every receive buffer that holds a packet is read
// - out packet arrival sets receive-complete and, if enabled, interrupt request
// - receive-complete validates status and clears only by writing one
// - out tokens with no forced or automatic stall pending get nak while receive-complete set and both buffers full
// - out bits 2 and 3 are reserved with no function
// - out sent-stall sets when forced stall reached the bus
// - automatic protocol stalls never set sent-stall
// - clear feature from host ends forced and automatic stalls
// - after stall clears no more stalls until force-stall is set again or a protocol error sets the automatic stall
// - while out force-stall is set, every out token gets stall
// - out force-stall clears itself when sent-stall sets
`timescale 1ns/1ps
module bec_bulk_ep_ctrl #(
  parameter int unsigned MAX_PKT = bec_pkg::MAX_PKT_BYTES
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input bec_pkg::bec_bus_req_t bus_i,
  output logic [bec_pkg::BUS_DATA_W-1:0] rd_data_o,
  input wire logic tx_byte_load_i,
  input wire logic rx_buf_drained_i,
  input wire logic rx_int_en_i,
  input bec_pkg::bec_sie_ev_t sie_i,
  output bec_pkg::bec_hs_t ep1_hs_o,
  output bec_pkg::bec_hs_t ep2_hs_o,
  output logic ep2_interrupt_request_o
);
  import bec_pkg::*;

  localparam int unsigned BYTE_W = $clog2(MAX_PKT);
  localparam logic [BYTE_W-1:0] LAST_BYTE = BYTE_W'(MAX_PKT - 1);

  typedef struct packed {
    logic [BYTE_W-1:0] tx_bytes;
    logic [1:0] tx_pkts;
    logic [1:0] rx_pkts;
    logic fst1;
    logic fst2;
    logic stall1;
    logic stall2;
    bec_hs_t hs1;
    bec_hs_t hs2;
    logic irq;
    logic [BUS_DATA_W-1:0] rdata;
  } bec_state_t;

  bec_state_t s_q;
  bec_state_t s_d;

  logic sst1;
  logic sst2;
  logic tx_undr_flag;
  logic tx_done_flag;
  logic rx_done_flag;

  logic wr_in;
  logic wr_out;
  logic sst1_set;
  logic sst2_set;
  logic tx_room;
  logic rx_ready;
  logic [CSR_W-1:0] in_csr;
  logic [CSR_W-1:0] out_csr;

  assign wr_in = bus_i.wr && (bus_i.addr == IN_CSR_OFS);
  assign wr_out = bus_i.wr && (bus_i.addr == OUT_CSR_OFS);
  assign sst1_set = sie_i.in_token && s_q.fst1;
  assign sst2_set = sie_i.out_token && s_q.fst2;
  assign tx_room = (s_q.tx_pkts < BUF_COUNT);
  assign rx_ready = (s_q.rx_pkts != 2'h0);

  always_comb begin
    in_csr = '0;
    in_csr[IN_FORCE_STALL] = s_q.fst1;
    in_csr[IN_SENT_STALL] = sst1;
    in_csr[IN_TX_UNDERRUN] = tx_undr_flag;
    in_csr[IN_TX_PACKET_COMPLETE] = tx_done_flag;
    in_csr[IN_TX_FIFO_SERVICE] = tx_room;
    out_csr = '0;
    out_csr[OUT_FORCE_STALL] = s_q.fst2;
    out_csr[OUT_SENT_STALL] = sst2;
    out_csr[OUT_RX_PACKET_COMPLETE] = rx_done_flag;
    out_csr[OUT_RX_FIFO_SERVICE] = rx_ready;
  end

  bec_sticky_flag u_sst1 (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .set_i(sst1_set),
    .clr_i(wr_in && bus_i.wdata[IN_SENT_STALL]),
    .flag_o(sst1)
  );

  bec_sticky_flag u_tx_undr (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .set_i(sie_i.tx_underrun),
    .clr_i(wr_in && bus_i.wdata[IN_TX_UNDERRUN]),
    .flag_o(tx_undr_flag)
  );

  bec_sticky_flag u_tx_done (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .set_i(sie_i.tx_sent),
    .clr_i(wr_in && bus_i.wdata[IN_TX_PACKET_COMPLETE]),
    .flag_o(tx_done_flag)
  );

  bec_sticky_flag u_sst2 (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .set_i(sst2_set),
    .clr_i(wr_out && bus_i.wdata[OUT_SENT_STALL]),
    .flag_o(sst2)
  );

  bec_sticky_flag u_rx_done (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .set_i(sie_i.rx_pkt_done),
    .clr_i(wr_out && bus_i.wdata[OUT_RX_PACKET_COMPLETE]),
    .flag_o(rx_done_flag)
  );

  always_comb begin
    logic tx_commit;
    logic tx_take;
    logic rx_put;
    logic rx_take;
    tx_commit = 1'b0;
    tx_take = 1'b0;
    rx_put = 1'b0;
    rx_take = 1'b0;
    s_d = s_q;
    s_d.hs1 = '{valid: 1'b0, code: HS_NAK};
    s_d.hs2 = '{valid: 1'b0, code: HS_NAK};
    s_d.irq = 1'b0;

    // transmit side: bytes fill a buffer, a full or short buffer becomes a packet
    if (tx_byte_load_i && tx_room) begin
      if (s_q.tx_bytes == LAST_BYTE) begin
        s_d.tx_bytes = '0;
        tx_commit = 1'b1;
      end else begin
        s_d.tx_bytes = s_q.tx_bytes + BYTE_W'(1);
      end
    end
    if (wr_in && bus_i.wdata[IN_TX_SHORT_PACKET] && tx_room) begin
      s_d.tx_bytes = '0;
      tx_commit = 1'b1;
    end
    tx_take = sie_i.tx_sent && (s_q.tx_pkts != 2'h0);
    if (tx_commit && !tx_take) begin
      s_d.tx_pkts = s_q.tx_pkts + 2'h1;
    end else if (!tx_commit && tx_take) begin
      s_d.tx_pkts = s_q.tx_pkts - 2'h1;
    end
    if (wr_in && bus_i.wdata[IN_TX_FIFO_FLUSH]) begin
      s_d.tx_pkts = 2'h0;
      s_d.tx_bytes = '0;
    end

    // in token answer: forced stall, then automatic stall, then data or nak
    if (sie_i.in_token) begin
      s_d.hs1.valid = 1'b1;
      if (s_q.fst1 || s_q.stall1) begin
        s_d.hs1.code = HS_STALL;
      end else if (s_q.tx_pkts != 2'h0) begin
        s_d.hs1.code = HS_DATA;
      end else begin
        s_d.hs1.code = HS_NAK;
      end
    end
    if (sie_i.in_proto_err) begin
      s_d.stall1 = 1'b1;
    end
    if (sie_i.in_clear_feature) begin
      s_d.stall1 = 1'b0;
      s_d.fst1 = 1'b0;
    end
    if (wr_in) begin
      s_d.fst1 = bus_i.wdata[IN_FORCE_STALL];
    end

    // receive side: two packet buffers, software drains one at a time
    rx_put = sie_i.rx_pkt_done && (s_q.rx_pkts != BUF_COUNT);
    rx_take = rx_buf_drained_i && (s_q.rx_pkts != 2'h0);
    if (rx_put && !rx_take) begin
      s_d.rx_pkts = s_q.rx_pkts + 2'h1;
    end else if (!rx_put && rx_take) begin
      s_d.rx_pkts = s_q.rx_pkts - 2'h1;
    end
    s_d.irq = sie_i.rx_pkt_done && rx_int_en_i;

    // out token answer
    if (sie_i.out_token) begin
      s_d.hs2.valid = 1'b1;
      if (s_q.fst2) begin
        s_d.hs2.code = HS_STALL;
        s_d.fst2 = 1'b0;
        s_d.stall2 = 1'b1;
      end else if (s_q.stall2) begin
        s_d.hs2.code = HS_STALL;
      end else if (rx_done_flag && (s_q.rx_pkts == BUF_COUNT)) begin
        s_d.hs2.code = HS_NAK;
      end else begin
        s_d.hs2.code = HS_ACK;
      end
    end
    if (sie_i.out_proto_err) begin
      s_d.stall2 = 1'b1;
    end
    if (sie_i.out_clear_feature) begin
      s_d.stall2 = 1'b0;
      s_d.fst2 = 1'b0;
    end
    // software write wins over a same-cycle auto-clear
    if (wr_out) begin
      s_d.fst2 = bus_i.wdata[OUT_FORCE_STALL];
    end

    // read data stands one cycle after the strobe only
    s_d.rdata = '0;
    if (bus_i.rd && (bus_i.addr == IN_CSR_OFS)) begin
      s_d.rdata = {{(BUS_DATA_W-CSR_W){1'b0}}, in_csr};
    end else if (bus_i.rd && (bus_i.addr == OUT_CSR_OFS)) begin
      s_d.rdata = {{(BUS_DATA_W-CSR_W){1'b0}}, out_csr};
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_q <= '{tx_bytes: '0, tx_pkts: 2'h0, rx_pkts: 2'h0, fst1: 1'b0, fst2: 1'b0,
               stall1: 1'b0, stall2: 1'b0, hs1: '{valid: 1'b0, code: HS_NAK},
               hs2: '{valid: 1'b0, code: HS_NAK}, irq: 1'b0, rdata: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign rd_data_o = s_q.rdata;
  assign ep1_hs_o = s_q.hs1;
  assign ep2_hs_o = s_q.hs2;
  assign ep2_interrupt_request_o = s_q.irq;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!nrst_i);

  sequence in_forced_tok_s;
    sie_i.in_token && s_q.fst1;
  endsequence

  sequence in_stall_ans_s;
    ep1_hs_o.valid && (ep1_hs_o.code == HS_STALL);
  endsequence

  in_force_stall_a: assert property (in_forced_tok_s |=> in_stall_ans_s ##1 sst1)
    else $error("forced in stall not answered or not flagged");

  sent_stall_hold_a: assert property (sst1 && !(wr_in && bus_i.wdata[IN_SENT_STALL]) |=> sst1)
    else $error("in sent-stall dropped without a write of one");

  in_rsvd_zero_a: assert property (bus_i.rd |=> !rd_data_o[IN_RSVD] && !rd_data_o[IN_TX_FIFO_FLUSH])
    else $error("reserved or flush bit read as one");

  // in-csr bit 3 is the underrun flag, so only out reads are checked here
  out_rsvd_zero_a: assert property (bus_i.rd && (bus_i.addr == OUT_CSR_OFS)
      |=> rd_data_o[OUT_RSVD_HI:OUT_RSVD_LO] == 2'h0)
    else $error("out reserved bits read as nonzero");

  underrun_flag_a: assert property (sie_i.tx_underrun |=> ##1 tx_undr_flag)
    else $error("underrun not flagged");

  tx_flush_a: assert property (wr_in && bus_i.wdata[IN_TX_FIFO_FLUSH]
      |=> s_q.tx_pkts == 2'h0 ##1 tx_room)
    else $error("flush left packets in transmit fifo");

  tx_complete_a: assert property (sie_i.tx_sent |=> ##1 tx_done_flag)
    else $error("transmit complete not flagged");

  tx_service_a: assert property (bus_i.rd && (bus_i.addr == IN_CSR_OFS)
      |=> rd_data_o[IN_TX_FIFO_SERVICE] == ($past(s_q.tx_pkts) < BUF_COUNT))
    else $error("transmit service bit wrong");

  tx_count_a: assert property (s_q.tx_pkts <= BUF_COUNT)
    else $error("transmit packet count past two buffers");

  rx_service_a: assert property (sie_i.rx_pkt_done |=> rx_ready)
    else $error("receive service not set after packet");

  rx_count_a: assert property (s_q.rx_pkts <= BUF_COUNT)
    else $error("receive packet count past two buffers");

  rx_irq_a: assert property (sie_i.rx_pkt_done && rx_int_en_i
      |=> ep2_interrupt_request_o ##1 rx_done_flag)
    else $error("receive complete or interrupt missing");

  rx_nak_a: assert property (sie_i.out_token && !s_q.fst2 && !s_q.stall2 && rx_done_flag
      && (s_q.rx_pkts == BUF_COUNT) |=> ep2_hs_o.valid && (ep2_hs_o.code == HS_NAK))
    else $error("out token not refused with both buffers full");

  out_force_stall_a: assert property (sie_i.out_token && s_q.fst2 && !wr_out
      |=> (ep2_hs_o.code == HS_STALL) && !s_q.fst2 ##1 sst2)
    else $error("forced out stall sequence wrong");

  auto_stall_quiet_a: assert property (sie_i.out_token && !s_q.fst2 && !sst2
      && !wr_out |=> ##1 !sst2)
    else $error("automatic stall set sent-stall");

  out_auto_quiet_a: assert property (sie_i.out_proto_err && !s_q.fst2 && !sst2
      |=> !sst2)
    else $error("automatic out stall set sent-stall");

  sequence out_cleared_s;
    sie_i.out_clear_feature && !wr_out;
  endsequence

  sequence out_quiet_gap_s;
    !sie_i.out_proto_err && !wr_out;
  endsequence

  sequence out_plain_tok_s;
    sie_i.out_token && !sie_i.out_proto_err;
  endsequence

  // the host model leaves one idle cycle between clear feature and the next token
  clear_feature_a: assert property (out_cleared_s ##1 out_quiet_gap_s
      ##1 out_plain_tok_s |=> ep2_hs_o.valid && (ep2_hs_o.code != HS_STALL))
    else $error("stall persisted after clear feature");

  out_stall_hold_a: assert property (s_q.stall2 && !sie_i.out_clear_feature |=> s_q.stall2)
    else $error("out stall state dropped without clear feature");

  in_auto_stall_a: assert property (sie_i.in_proto_err && !sie_i.in_clear_feature
      ##1 !sie_i.in_clear_feature ##1 sie_i.in_token
      |=> ep1_hs_o.valid && (ep1_hs_o.code == HS_STALL))
    else $error("automatic in stall not answered");

  rd_idle_zero_a: assert property (!bus_i.rd |=> rd_data_o == '0)
    else $error("read data not zero outside the answer cycle");

  hs_idle_a: assert property (!sie_i.in_token && !sie_i.out_token
      |=> !ep1_hs_o.valid && !ep2_hs_o.valid)
    else $error("handshake without a token");

endmodule : bec_bulk_ep_ctrl

// ---- testbench/bec_host_model.sv ----
`timescale 1ns/1ps
module bec_host_model (
  input wire logic sys_clk_i,
  input bec_pkg::bec_hs_t ep1_hs_i,
  input bec_pkg::bec_hs_t ep2_hs_i,
  output bec_pkg::bec_sie_ev_t sie_o
);
  import bec_pkg::*;
  initial sie_o = '0;
  // one-cycle bus event, e.g. tokens or clear feature for an endpoint
  task ev(input bec_sie_ev_t e);
    @(posedge sys_clk_i);
    sie_o <= e;
    @(posedge sys_clk_i);
    sie_o <= '0;
  endtask : ev
  // handshake stands one cycle only, so it is caught right after the taking edge
  task tok(input logic ep2, output bec_hs_t h);
    ev(ep2 ? 9'h080 : 9'h100);
    #1;
    h = ep2 ? ep2_hs_i : ep1_hs_i;
  endtask : tok
endmodule : bec_host_model

// ---- testbench/test_bec_bulk_ep_ctrl.sv ----
`timescale 1ns/1ps
module test_bec_bulk_ep_ctrl;
  import bec_pkg::*;
  localparam logic [8:0] TXS = 9'h040;
  localparam logic [8:0] UNDR = 9'h020;
  localparam logic [8:0] OPE = 9'h004;
  localparam logic [8:0] RXD = 9'h010;
  localparam logic [8:0] IPE = 9'h008;
  localparam logic [8:0] ICF = 9'h002;
  localparam logic [8:0] OCF = 9'h001;
  logic sys_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  bec_bus_req_t bus = '0;
  logic [31:0] rd_data;
  logic ld = 1'b0;
  logic drn = 1'b0;
  logic int_en = 1'b1;
  logic irq;
  bec_sie_ev_t sie;
  bec_hs_t hs1;
  bec_hs_t hs2;
  bec_hs_t h;
  int n_mismatch = 0;
  int samples_checked = 0;

  always #12.5 sys_clk_i = ~sys_clk_i;

  bec_bulk_ep_ctrl bec_bulk_ep_ctrl_i (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .bus_i(bus),
    .rd_data_o(rd_data),
    .tx_byte_load_i(ld),
    .rx_buf_drained_i(drn),
    .rx_int_en_i(int_en),
    .sie_i(sie),
    .ep1_hs_o(hs1),
    .ep2_hs_o(hs2),
    .ep2_interrupt_request_o(irq)
  );

  bec_host_model bec_host_model_i (
    .sys_clk_i(sys_clk_i),
    .ep1_hs_i(hs1),
    .ep2_hs_i(hs2),
    .sie_o(sie)
  );

  task finish_test;
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test

  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: {24'h0, d}};
    @(posedge sys_clk_i);
    bus <= '0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk_i);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge sys_clk_i);
    bus <= '0;
    #1;
    chk("rd_data", rd_data, {24'h0, e});
  endtask : rd

  task tk(input logic ep2, input logic [2:0] e);
    bec_host_model_i.tok(ep2, h);
    chk("hs", 32'(h), 32'(e));
  endtask : tk

  // normal answer: valid, anything but stall
  task tkn(input logic ep2);
    bec_host_model_i.tok(ep2, h);
    chk("hs_nostall", 32'({h.valid, h.code == HS_STALL}), 32'h2);
  endtask : tkn

  task load(input int n);
    repeat (n) @(posedge sys_clk_i) ld <= 1'b1;
    @(posedge sys_clk_i);
    ld <= 1'b0;
  endtask : load

  initial begin
    #(25 * 4000);
    n_mismatch++;
    finish_test();
  end

  initial begin
    repeat (3) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    rd(8'h00, 8'h01);
    rd(8'h04, 8'h00);
    wr(8'h08, 8'hff);
    rd(8'h08, 8'h00);
    rd(8'h00, 8'h01);
    wr(8'h00, 8'h20);
    tk(1'b0, 3'h7);
    rd(8'h00, 8'h31);
    wr(8'h00, 8'h30);
    rd(8'h00, 8'h21);
    bec_host_model_i.ev(ICF);
    rd(8'h00, 8'h01);
    tkn(1'b0);
    bec_host_model_i.ev(IPE);
    tk(1'b0, 3'h7);
    rd(8'h00, 8'h01);
    bec_host_model_i.ev(ICF);
    tkn(1'b0);
    bec_host_model_i.ev(UNDR);
    rd(8'h00, 8'h09);
    wr(8'h00, 8'h08);
    rd(8'h00, 8'h01);
    load(128);
    rd(8'h00, 8'h00);
    wr(8'h00, 8'h04);
    rd(8'h00, 8'h01);
    load(3);
    wr(8'h00, 8'h80);
    load(64);
    rd(8'h00, 8'h00);
    bec_host_model_i.ev(TXS);
    rd(8'h00, 8'h03);
    wr(8'h00, 8'h06);
    rd(8'h00, 8'h01);
    bec_host_model_i.ev(RXD);
    #1;
    chk("irq", 32'(irq), 32'h1);
    rd(8'h04, 8'h03);
    @(posedge sys_clk_i) int_en <= 1'b0;
    bec_host_model_i.ev(RXD);
    #1;
    chk("irq", 32'(irq), 32'h0);
    tk(1'b1, 3'h6);
    wr(8'h04, 8'h02);
    rd(8'h04, 8'h01);
    tkn(1'b1);
    @(posedge sys_clk_i) drn <= 1'b1;
    @(posedge sys_clk_i) drn <= 1'b0;
    rd(8'h04, 8'h01);
    @(posedge sys_clk_i) drn <= 1'b1;
    @(posedge sys_clk_i) drn <= 1'b0;
    rd(8'h04, 8'h00);
    wr(8'h04, 8'h20);
    tk(1'b1, 3'h7);
    rd(8'h04, 8'h10);
    tk(1'b1, 3'h7);
    bec_host_model_i.ev(OCF);
    tkn(1'b1);
    rd(8'h04, 8'h10);
    wr(8'h04, 8'h10);
    rd(8'h04, 8'h00);
    bec_host_model_i.ev(OPE);
    tk(1'b1, 3'h7);
    rd(8'h04, 8'h00);
    bec_host_model_i.ev(OCF);
    tkn(1'b1);
    bec_host_model_i.ev(RXD);
    wr(8'h04, 8'h20);
    tk(1'b1, 3'h7);
    bec_host_model_i.ev(OCF);
    rd(8'h04, 8'h13);
    finish_test();
  end
endmodule : test_bec_bulk_ep_ctrl
